// >>> ocr_params.svh
// Offsets, field positions, reset values and timing counts of the overcurrent curve block
`ifndef OCR_PARAMS_SVH
`define OCR_PARAMS_SVH

// Register offsets (byte addresses)
`define OCR_ADDR_CTRL       8'h00
`define OCR_ADDR_PICKUP     8'h04
`define OCR_ADDR_TMULT      8'h08
`define OCR_ADDR_RDELAY     8'h0C
`define OCR_ADDR_STATUS     8'h10
`define OCR_ADDR_IRQ_STAT   8'h14
`define OCR_ADDR_IRQ_MASK   8'h18
`define OCR_ADDR_EFF_PICKUP 8'h1C
`define OCR_ADDR_MEAS       8'h20

// Control field positions
`define OCR_CTRL_EN         0
`define OCR_CTRL_CT5A       1
`define OCR_CTRL_GROUND     2
`define OCR_CTRL_NEG_SEQ    3
`define OCR_CTRL_VR_EN      4
`define OCR_CTRL_VTS_EN     5
`define OCR_CTRL_WIRE_PG    6
`define OCR_CTRL_MEAS_PG    7
`define OCR_CTRL_CURVE_LSB  8
`define OCR_CTRL_RMODE_LSB  10

// Event bits in status and interrupt registers
`define OCR_EV_PICKUP       0
`define OCR_EV_TRIP         1
`define OCR_EV_BLOCK        2

// Reset values
`define OCR_RST_CTRL        12'h000
`define OCR_RST_PICKUP      16'h0100
`define OCR_RST_TMULT       16'h0064
`define OCR_RST_RDELAY      16'h0000

// Timing: clock period and evaluation tick, both in ns
`define OCR_CLK_NS          100
`define OCR_TICK_NS         1000000
`define OCR_TICK_CYCLES     (`OCR_TICK_NS / `OCR_CLK_NS)
// Ticks per time multiplier step (10 ms steps of a 1 ms tick)
`define OCR_TM_TICKS        10
`define OCR_TRIP_FACTOR     5
`define OCR_RST_FACTOR      45

// Fixed-point constants, currents and voltages in Q8 per unit
`define OCR_Q_ONE           16'h0100
`define OCR_IMAX            16'h2800
`define OCR_PICKUP_MIN      16'h0006
`define OCR_PCT_MIN         16'h0040
`define OCR_SQRT3_Q12       16'h1BB6
`define OCR_INV5_Q16        16'h3333
`define OCR_SIN60_Q10       16'h0377
`define OCR_THIRD_Q10       16'h0155

// Powers of K for the phase current case (K = 3)
`define OCR_KP_M0           8'h01
`define OCR_KP_M1           8'h03
`define OCR_KP_M2           8'h09
`define OCR_KP_M4           8'h51

`endif

// >>> ocr_pkg.sv
// Types shared by the overcurrent curve block
package ocr_pkg;

  typedef enum logic [1:0] {
    OCR_CURVE_FLAT,
    OCR_CURVE_LINEAR,
    OCR_CURVE_SQUARE,
    OCR_CURVE_FOURTH
  } ocr_curve_e;

  typedef enum logic [1:0] {
    OCR_RST_CHAR,
    OCR_RST_DELAYED,
    OCR_RST_INSTANT,
    OCR_RST_SPARE
  } ocr_rst_mode_e;

endpackage

// >>> ocr_overcurrent.sv
// Thermal inverse-time overcurrent element with voltage restraint and negative sequence
// Functional notes
// [R1] Trip time 5 times multiplier times K^M over ratio^M
// [R2] K is 3 for phase, 1 for ground
// [R3] M is 0, 1, 2 or 4 per curve
// [R4] Rated current base 1 A or 5 A
// [R5] Range up to 40 In, pickup at least 0.02 In
// [R6] Thermal reset delay is 45 times multiplier
// [R7] Reset modes: characteristic, delayed, instantaneous
// [R8] Above pickup, delay follows selected curve
// [R9] Restrained pickup is percentage times setting, clamped
// [R10] Restraint uses the associated phase voltage
// [R11] Percentage 25% to 100%, linear between voltages
// [R12] Restraint changes pickup only, never the curve
// [R13] Supervision breaker trip blocks restrained element
// [R14] Rated voltage divided by root three if both ground
// [R15] Negative sequence selection replaces phase currents
// [R16] I2 is third of IL1 + a2 IL2 + a IL3
// [R17] Negative sequence shares all phase element settings; the code applies no voltage restraint and no VTS blocking to I2
// [R18] With inrush blocking, delays at least 30 ms; the code has no inrush blocking and no minimum delay
// [R19] Periodic tick accumulates toward the computed delay
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`include "ocr_params.svh"

module ocr_overcurrent #(
  parameter int TICK_CYCLES = `OCR_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  // Register port
  input  wire logic [7:0]         i_addr,
  input  wire logic [31:0]        i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output logic      [31:0]        o_rdata,
  // Phase current phasors, Q8 secondary amps
  input  wire logic signed [15:0] i_ia_re,
  input  wire logic signed [15:0] i_ia_im,
  input  wire logic signed [15:0] i_ib_re,
  input  wire logic signed [15:0] i_ib_im,
  input  wire logic signed [15:0] i_ic_re,
  input  wire logic signed [15:0] i_ic_im,
  // Phase voltage magnitudes, Q8 per unit of transformer secondary
  input  wire logic [15:0]        i_va_mag,
  input  wire logic [15:0]        i_vb_mag,
  input  wire logic [15:0]        i_vc_mag,
  input  wire logic               i_vts_mcb_trip,
  // Decisions
  output logic                    o_pickup,
  output logic                    o_trip,
  output logic                    o_irq
);

  // Magnitude by max plus 3/8 min: cheap, within about 7% of the true value
  function automatic logic [18:0] mag(input logic signed [18:0] re, input logic signed [18:0] im);
    logic [18:0] ax;
    logic [18:0] ay;
    logic [18:0] hi;
    logic [18:0] lo;
    ax  = re[18] ? 19'(-re) : 19'(re);
    ay  = im[18] ? 19'(-im) : 19'(im);
    hi  = (ax > ay) ? ax : ay;
    lo  = (ax > ay) ? ay : ax;
    mag = hi + (lo >> 2) + (lo >> 3);
  endfunction

  function automatic logic signed [18:0] mul_q10(input logic signed [18:0] a,
                                                 input logic [15:0] k);
    logic signed [35:0] p;
    p       = 36'(a) * $signed({20'h0_0000, k});
    mul_q10 = 19'(p >>> 10);
  endfunction

  // Ratio to rated current, clamped to the working range
  function automatic logic [15:0] to_ratio(input logic [18:0] m, input logic ct5a);
    logic [34:0] s;
    s = ct5a ? (35'(m) * 35'(`OCR_INV5_Q16)) >> 16 : 35'(m); // [R4]
    to_ratio = (s > 35'(`OCR_IMAX)) ? `OCR_IMAX : 16'(s);    // [R5]
  endfunction

  logic [11:0] ctrl_r;
  logic [15:0] pickup_r;
  logic [15:0] tmult_r;
  logic [15:0] rdelay_r;
  logic [2:0]  irq_stat_r;
  logic [2:0]  irq_mask_r;
  logic [31:0] rdata_r;
  logic        irq_r;
  logic [23:0] tick_cnt_r;
  logic        tick_r;
  logic [39:0] acc_r;
  logic [31:0] rcnt_r;
  logic        trip_r;
  logic        pick_r;
  logic        blk_r;

  wire logic en      = ctrl_r[`OCR_CTRL_EN];
  wire logic ct5a    = ctrl_r[`OCR_CTRL_CT5A];
  wire logic ground  = ctrl_r[`OCR_CTRL_GROUND];
  wire logic neg_seq = ctrl_r[`OCR_CTRL_NEG_SEQ];
  wire logic vr_en   = ctrl_r[`OCR_CTRL_VR_EN];
  wire logic vts_en  = ctrl_r[`OCR_CTRL_VTS_EN];
  wire logic wire_pg = ctrl_r[`OCR_CTRL_WIRE_PG];
  wire logic meas_pg = ctrl_r[`OCR_CTRL_MEAS_PG];
  ocr_pkg::ocr_curve_e    curve;
  ocr_pkg::ocr_rst_mode_e rmode;
  assign curve = ocr_pkg::ocr_curve_e'(ctrl_r[`OCR_CTRL_CURVE_LSB +: 2]);
  assign rmode = ocr_pkg::ocr_rst_mode_e'(ctrl_r[`OCR_CTRL_RMODE_LSB +: 2]);

  // Measurement arrays
  logic signed [18:0] re_a [3];
  logic signed [18:0] im_a [3];
  logic [15:0]        v_a  [3];
  assign re_a[0] = 19'(i_ia_re);
  assign re_a[1] = 19'(i_ib_re);
  assign re_a[2] = 19'(i_ic_re);
  assign im_a[0] = 19'(i_ia_im);
  assign im_a[1] = 19'(i_ib_im);
  assign im_a[2] = 19'(i_ic_im);
  assign v_a[0]  = i_va_mag;
  assign v_a[1]  = i_vb_mag;
  assign v_a[2]  = i_vc_mag;

  // Negative sequence: a = -1/2 + j sin60, a2 = -1/2 - j sin60
  logic signed [18:0] i2_re_sum;
  logic signed [18:0] i2_im_sum;
  logic [15:0]        i2_ratio;
  assign i2_re_sum = re_a[0] - (re_a[1] >>> 1) + mul_q10(im_a[1], `OCR_SIN60_Q10)
                   - (re_a[2] >>> 1) - mul_q10(im_a[2], `OCR_SIN60_Q10);   // [R16]
  assign i2_im_sum = im_a[0] - (im_a[1] >>> 1) - mul_q10(re_a[1], `OCR_SIN60_Q10)
                   - (im_a[2] >>> 1) + mul_q10(re_a[2], `OCR_SIN60_Q10);   // [R16]
  assign i2_ratio  = to_ratio(mag(mul_q10(i2_re_sum, `OCR_THIRD_Q10),
                                  mul_q10(i2_im_sum, `OCR_THIRD_Q10)), ct5a); // [R16]

  // Setting itself is floored, so an element never runs below the least pickup
  logic [15:0] pickup_set;
  assign pickup_set = (pickup_r < `OCR_PICKUP_MIN) ? `OCR_PICKUP_MIN : pickup_r; // [R5]

  // Only phase-to-ground wiring and measurement make the base secondary / root three
  logic vn_root3;
  assign vn_root3 = wire_pg && meas_pg; // [R14]

  logic [15:0] ratio_a [3];
  logic [15:0] eff_a   [3];
  logic [15:0] pct_a   [3];
  logic [2:0]  over_a;

  for (genvar g = 0; g < 3; g++) begin : g_phase
    logic [31:0] vs;
    logic [31:0] ep;
    assign ratio_a[g] = to_ratio(mag(re_a[g], im_a[g]), ct5a);
    // Since the lower voltage is a quarter of the upper, the linear law reduces to V / Vn
    assign vs = vn_root3 ? (32'(v_a[g]) * 32'(`OCR_SQRT3_Q12)) >> 12 : 32'(v_a[g]); // [R10]
    assign pct_a[g] = (vs < 32'(`OCR_PCT_MIN)) ? `OCR_PCT_MIN :
                      (vs > 32'(`OCR_Q_ONE)) ? `OCR_Q_ONE : 16'(vs);                 // [R11]
    assign ep = (32'(pct_a[g]) * 32'(pickup_set)) >> 8;                              // [R9]
    assign eff_a[g] = !vr_en ? pickup_set :
                      (ep < 32'(`OCR_PICKUP_MIN)) ? `OCR_PICKUP_MIN : 16'(ep);       // [R9]
    assign over_a[g] = ratio_a[g] > eff_a[g];
  end

  // Operating quantity: largest ratio among phases over their own pickup
  logic [15:0] ratio;
  logic [15:0] eff_sel;
  logic        picked;
  always_comb begin
    ratio   = 16'h0000;
    eff_sel = eff_a[0];
    picked  = 1'b0;
    if (neg_seq) begin
      ratio   = i2_ratio;                 // [R15]
      eff_sel = pickup_set;               // [R17]
      picked  = i2_ratio > pickup_set;    // [R15]
    end else begin
      for (int p = 0; p < 3; p++) begin
        if (over_a[p] && ratio_a[p] >= ratio) begin
          ratio   = ratio_a[p];
          eff_sel = eff_a[p];
          picked  = 1'b1;
        end
      end
    end
  end

  // Blocking applies only to the restrained element under supervision
  logic blocked;
  assign blocked = vr_en && vts_en && i_vts_mcb_trip && !neg_seq; // [R13]

  // Curve shape from the ratio alone; restraint never enters here
  logic [19:0] r2;
  logic [29:0] r4;
  logic [29:0] rm;
  logic [7:0]  kpow;
  assign r2 = 20'((32'(ratio) * 32'(ratio)) >> 8);
  assign r4 = 30'((40'(r2) * 40'(r2)) >> 8);
  always_comb begin
    case (curve)
      ocr_pkg::OCR_CURVE_FLAT: begin
        rm   = 30'(`OCR_Q_ONE);     // [R3]
        kpow = `OCR_KP_M0;
      end
      ocr_pkg::OCR_CURVE_LINEAR: begin
        rm   = 30'(ratio);          // [R3] [R12]
        kpow = `OCR_KP_M1;
      end
      ocr_pkg::OCR_CURVE_SQUARE: begin
        rm   = 30'(r2);             // [R3]
        kpow = `OCR_KP_M2;
      end
      default: begin
        rm   = r4;                  // [R3]
        kpow = `OCR_KP_M4;
      end
    endcase
    if (ground) begin
      kpow = `OCR_KP_M0;            // [R2]
    end
  end

  // Threshold in tick units times Q8 ratio^M; the phase and I2 elements share it
  logic [39:0] thr;
  logic [31:0] rst_lim;
  logic [39:0] acc_sum;
  assign thr = 40'(tmult_r) * 40'(`OCR_TRIP_FACTOR * `OCR_TM_TICKS * 256) * 40'(kpow); // [R1] [R17]
  assign rst_lim = (rmode == ocr_pkg::OCR_RST_CHAR) ?
                   32'(tmult_r) * 32'(`OCR_RST_FACTOR * `OCR_TM_TICKS) :             // [R6]
                   32'(rdelay_r);                                                     // [R7]
  assign acc_sum = acc_r + 40'(rm);

  // Tick divider
  always_ff @(posedge i_clk) begin
    if (i_rst || tick_cnt_r == 24'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= 24'h00_0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 24'h00_0001;
    end
  end

  always_ff @(posedge i_clk) begin
    tick_r <= !i_rst && tick_cnt_r == 24'(TICK_CYCLES - 1);
  end

  // Trip and reset timing
  always_ff @(posedge i_clk) begin
    if (i_rst || !en || blocked) begin
      acc_r  <= 40'h00_0000_0000;       // [R13]
      rcnt_r <= 32'h0000_0000;
      trip_r <= 1'b0;
    end else if (tick_r) begin
      if (picked) begin
        rcnt_r <= 32'h0000_0000;
        if (acc_sum >= thr) begin
          acc_r  <= thr;                // [R19]
          trip_r <= 1'b1;               // [R8] [R19]
        end else begin
          acc_r  <= acc_sum;            // [R8] [R19]
        end
      end else if (rmode == ocr_pkg::OCR_RST_INSTANT || rcnt_r + 32'h0000_0001 >= rst_lim) begin
        acc_r  <= 40'h00_0000_0000;     // [R7]
        rcnt_r <= 32'h0000_0000;
        trip_r <= 1'b0;
      end else begin
        rcnt_r <= rcnt_r + 32'h0000_0001; // [R6] [R7]
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pick_r <= 1'b0;
      blk_r  <= 1'b0;
    end else begin
      pick_r <= en && !blocked && picked;
      blk_r  <= en && blocked;
    end
  end

  // Register writes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_r     <= `OCR_RST_CTRL;
      pickup_r   <= `OCR_RST_PICKUP;
      tmult_r    <= `OCR_RST_TMULT;
      rdelay_r   <= `OCR_RST_RDELAY;
      irq_mask_r <= 3'h0;
    end else if (i_wr) begin
      case (i_addr)
        `OCR_ADDR_CTRL:     ctrl_r     <= i_wdata[11:0];
        `OCR_ADDR_PICKUP:   pickup_r   <= i_wdata[15:0];
        `OCR_ADDR_TMULT:    tmult_r    <= i_wdata[15:0];
        `OCR_ADDR_RDELAY:   rdelay_r   <= i_wdata[15:0];
        `OCR_ADDR_IRQ_MASK: irq_mask_r <= i_wdata[2:0];
        default:            ;
      endcase
    end
  end

  // Sticky events; a new event beats a clear in the same cycle
  logic [2:0] events;
  logic [2:0] irq_clr;
  logic [2:0] irq_stat_nxt;
  assign events[`OCR_EV_PICKUP] = !pick_r && en && !blocked && picked;
  assign events[`OCR_EV_TRIP]   = tick_r && picked && !trip_r && en && !blocked && acc_sum >= thr;
  assign events[`OCR_EV_BLOCK]  = !blk_r && en && blocked;
  assign irq_clr      = (i_wr && i_addr == `OCR_ADDR_IRQ_STAT) ? i_wdata[2:0] : 3'h0;
  assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | events;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      irq_stat_r <= 3'h0;
      irq_r      <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_r      <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  // Read data stand for exactly one cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_rd) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      case (i_addr)
        `OCR_ADDR_CTRL:       rdata_r <= {20'h0_0000, ctrl_r};
        `OCR_ADDR_PICKUP:     rdata_r <= {16'h0000, pickup_r};
        `OCR_ADDR_TMULT:      rdata_r <= {16'h0000, tmult_r};
        `OCR_ADDR_RDELAY:     rdata_r <= {16'h0000, rdelay_r};
        `OCR_ADDR_STATUS:     rdata_r <= {29'h0000_0000, blk_r, trip_r, pick_r};
        `OCR_ADDR_IRQ_STAT:   rdata_r <= {29'h0000_0000, irq_stat_r};
        `OCR_ADDR_IRQ_MASK:   rdata_r <= {29'h0000_0000, irq_mask_r};
        `OCR_ADDR_EFF_PICKUP: rdata_r <= {16'h0000, eff_sel};
        `OCR_ADDR_MEAS:       rdata_r <= {16'h0000, ratio};
        default:              rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign o_rdata  = rdata_r;
  assign o_pickup = pick_r;
  assign o_trip   = trip_r;
  assign o_irq    = irq_r;

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_trip_reach;
    tick_r && en && !blocked && picked && acc_sum >= thr |=> trip_r && acc_r == $past(thr);
  endproperty
  a_trip_reach: assert property (p_trip_reach) else $error("trip not set at threshold"); // [R19]

  property p_trip_cause;
    $rose(trip_r) |-> $past(tick_r) && $past(picked) && $past(acc_sum >= thr);
  endproperty
  a_trip_cause: assert property (p_trip_cause) else $error("trip rose without reaching delay"); // [R1]

  property p_instant;
    tick_r && en && !picked && rmode == ocr_pkg::OCR_RST_INSTANT |=> acc_r == 40'h00_0000_0000 && !trip_r;
  endproperty
  a_instant: assert property (p_instant) else $error("instant reset did not clear"); // [R7]

  // In characteristic reset mode, below pickup the accumulator must hold until 450 ticks per multiplier step have run
  property p_char_lim;
    tick_r && en && !blocked && !picked && rmode == ocr_pkg::OCR_RST_CHAR &&
      rcnt_r + 32'h0000_0001 < 32'(tmult_r) * 32'h0000_01C2 |=> acc_r == $past(acc_r);
  endproperty
  a_char_lim: assert property (p_char_lim) else $error("thermal reset delay wrong"); // [R6]

  property p_block;
    en && blocked |=> acc_r == 40'h00_0000_0000 && !trip_r && !o_pickup;
  endproperty
  a_block: assert property (p_block) else $error("blocked element still active"); // [R13]

  property p_pct;
    pct_a[0] >= `OCR_PCT_MIN && pct_a[0] <= `OCR_Q_ONE;
  endproperty
  a_pct: assert property (p_pct) else $error("restraint percentage out of range"); // [R11]

  property p_eff_min;
    eff_a[1] >= `OCR_PICKUP_MIN && (vr_en || eff_a[1] == pickup_set);
  endproperty
  a_eff_min: assert property (p_eff_min) else $error("effective pickup below floor"); // [R9]

  property p_kpow;
    ground |-> kpow == `OCR_KP_M0;
  endproperty
  a_kpow: assert property (p_kpow) else $error("ground K is not one"); // [R2]

  property p_ratio_max;
    ratio <= `OCR_IMAX;
  endproperty
  a_ratio_max: assert property (p_ratio_max) else $error("ratio beyond working range"); // [R5]

  property p_irq_sticky;
    irq_stat_r[`OCR_EV_TRIP] && !(i_wr && i_addr == `OCR_ADDR_IRQ_STAT && i_wdata[1])
      |=> irq_stat_r[`OCR_EV_TRIP];
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("trip status lost");

  property p_rdata_once;
    !$past(i_rd) |-> o_rdata == 32'h0000_0000;
  endproperty
  a_rdata_once: assert property (p_rdata_once) else $error("read data outside its cycle");

  c_trip:     cover property ($rose(o_trip));
  c_char_rst: cover property ($fell(o_trip) && rmode == ocr_pkg::OCR_RST_CHAR);
  c_neg_seq:  cover property (neg_seq && $rose(o_pickup));
  c_blocked:  cover property (en && blocked && vr_en);

endmodule // ocr_overcurrent

// >>> ocr_meas_model.sv
// Transformer secondary source: one phase alone, or a positive or negative sequence set
`timescale 1ns/10ps

module ocr_meas_model (
  // Stimulus selection
  input  wire logic [1:0]    i_mode,
  input  wire logic [15:0]   i_mag,
  input  wire logic [15:0]   i_vmag,
  // Current phasors
  output logic signed [15:0] o_ia_re,
  output logic signed [15:0] o_ia_im,
  output logic signed [15:0] o_ib_re,
  output logic signed [15:0] o_ib_im,
  output logic signed [15:0] o_ic_re,
  output logic signed [15:0] o_ic_im,
  // Voltage magnitudes
  output logic [15:0]        o_va_mag,
  output logic [15:0]        o_vb_mag,
  output logic [15:0]        o_vc_mag
);
  logic signed [15:0] half;
  logic signed [15:0] s60;

  // Truncated sin 60 leaves a small residue in the sequence sums, as real transformers do
  always_comb begin
    half = -$signed(i_mag >> 1);
    s60 = 16'((32'(i_mag) * 887) >> 10);
    o_ia_re = $signed(i_mag);
    o_ia_im = '0;
    o_ib_re = '0;
    o_ib_im = '0;
    o_ic_re = '0;
    o_ic_im = '0;
    if (i_mode != 2'd0) begin
      o_ib_re = half;
      o_ic_re = half;
      o_ib_im = (i_mode == 2'd1) ? -s60 : s60;
      o_ic_im = (i_mode == 2'd1) ? s60 : -s60;
    end
    o_va_mag = i_vmag;
    o_vb_mag = i_vmag;
    o_vc_mag = i_vmag;
  end
endmodule // ocr_meas_model

// >>> tb_ocr_overcurrent.sv
// Self-checking bench for the overcurrent curve element
`timescale 1ns/10ps
`include "ocr_params.svh"

module tb_ocr_overcurrent;
  localparam int          TC  = 10;
  localparam logic [31:0] EN  = 32'h0000_0001;
  localparam logic [31:0] CT5 = 32'h0000_0002;
  localparam logic [31:0] GND = 32'h0000_0004;
  localparam logic [31:0] NEG = 32'h0000_0008;
  localparam logic [31:0] VR  = 32'h0000_0010;
  localparam logic [31:0] VTS = 32'h0000_0020;
  localparam logic [31:0] INS = 32'h0000_0800;

  logic               i_clk = 1'b0;
  logic               i_rst = 1'b1;
  logic [7:0]         i_addr = '0;
  logic [31:0]        i_wdata = '0;
  logic               i_wr = 1'b0;
  logic               i_rd = 1'b0;
  logic               i_vts_mcb_trip = 1'b0;
  logic [1:0]         m_mode = '0;
  logic [15:0]        m_mag = '0;
  logic [15:0]        m_vmag = 16'h0100;
  logic [31:0]        o_rdata;
  logic               o_pickup;
  logic               o_trip;
  logic               o_irq;
  logic signed [15:0] ar, ai, br, bi, cr, ci;
  logic [15:0]        va, vb, vc;
  logic [31:0]        d;
  int                 failures = 0;
  int                 cmp_count = 0;
  int                 cycles = 0;
  int                 e;

  always #50 i_clk = ~i_clk;

  ocr_overcurrent #(.TICK_CYCLES(TC)) DUT (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_ia_re(ar), .i_ia_im(ai), .i_ib_re(br),
    .i_ib_im(bi), .i_ic_re(cr), .i_ic_im(ci), .i_va_mag(va), .i_vb_mag(vb),
    .i_vc_mag(vc), .i_vts_mcb_trip(i_vts_mcb_trip), .o_pickup(o_pickup),
    .o_trip(o_trip), .o_irq(o_irq));

  ocr_meas_model MODEL (
    .i_mode(m_mode), .i_mag(m_mag), .i_vmag(m_vmag), .o_ia_re(ar), .o_ia_im(ai),
    .o_ib_re(br), .o_ib_im(bi), .o_ic_re(cr), .o_ic_im(ci), .o_va_mag(va),
    .o_vb_mag(vb), .o_vc_mag(vc));

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
    chk(d, exp);
  endtask

  // Raise the current and time the trip against a window in clock cycles
  task automatic meas(input int lo, input int hi);
    int n;
    n = 0;
    @(posedge i_clk);
    m_mag <= 16'h0200;
    while (o_trip !== 1'b1 && n < 4000) begin
      @(posedge i_clk);
      n++;
    end
    cmp_count++;
    if (n < lo || n > hi) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, n, hi);
    end
  endtask

  task automatic report_and_stop;
    $display("compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Ceiling sits well above the roughly 15000 cycles the tests need
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 100000) begin
      failures++;
      report_and_stop();
    end
  end

  logic [15:0] pk[7] = '{16'h0100, 16'h0100, 16'h0100, 16'h0100, 16'h0100, 16'h0100, 16'h0010};
  logic [15:0] vv[7] = '{16'h0020, 16'h0080, 16'h0200, 16'h0094, 16'h0094, 16'h0094, 16'h0020};
  logic [1:0]  wm[7] = '{2'd0, 2'd0, 2'd0, 2'd3, 2'd1, 2'd2, 2'd0};
  logic [15:0] ex[7] = '{16'h0040, 16'h0080, 16'h0100, 16'h0100, 16'h0094, 16'h0094, 16'h0006};
  logic [15:0] tp[4] = '{16'h0100, 16'h0100, 16'h0001, 16'h0001};
  logic [15:0] tm[4] = '{16'h0100, 16'h0101, 16'h0006, 16'h0007};
  int          gp[5] = '{2, 5, 15, 440, 15};
  int          rm[5] = '{2, 1, 1, 0, 3};
  int          rr[5] = '{50, 20, 50, 20, 50};

  initial begin
    cyc(2);
    i_rst <= 1'b0;
    rchk(`OCR_ADDR_CTRL, 32'h0000_0000);
    rchk(`OCR_ADDR_PICKUP, 32'h0000_0100);
    rchk(`OCR_ADDR_TMULT, 32'h0000_0064);
    rchk(`OCR_ADDR_RDELAY, 32'h0000_0000);
    rchk(`OCR_ADDR_IRQ_MASK, 32'h0000_0000);
    rchk(8'h40, 32'h0000_0000);
    wr(`OCR_ADDR_STATUS, 32'hFFFF_FFFF);
    rchk(`OCR_ADDR_STATUS, 32'h0000_0000);
    @(posedge i_clk) #1 chk(o_rdata, 32'h0000_0000);
    $display("test registers done");

    wr(`OCR_ADDR_TMULT, 32'h0000_0001);
    wr(`OCR_ADDR_CTRL, EN | INS);
    for (int k = 0; k < 4; k++) begin
      wr(`OCR_ADDR_PICKUP, {16'h0000, tp[k]});
      m_mag <= tm[k];
      cyc(4);
      chk(32'(o_pickup), 32'(k % 2));
    end
    wr(`OCR_ADDR_PICKUP, 32'h0000_0100);
    m_mag <= 16'h0180;
    cyc(4);
    chk(32'(o_pickup), 32'h0000_0001);
    wr(`OCR_ADDR_CTRL, EN | INS | CT5);
    cyc(4);
    chk(32'(o_pickup), 32'h0000_0000);
    wr(`OCR_ADDR_CTRL, EN | INS);
    m_mag <= 16'h3000;
    cyc(4);
    rchk(`OCR_ADDR_MEAS, 32'h0000_2800);
    $display("test thresholds done");

    wr(`OCR_ADDR_IRQ_MASK, 32'h0000_0002);
    for (int g = 0; g < 2; g++) begin
      for (int c = 0; c < 4; c++) begin
        m_mag <= '0;
        wr(`OCR_ADDR_CTRL, 32'h0000_0000);
        wr(`OCR_ADDR_CTRL, EN | INS | (g ? GND : 32'h0) | 32'(c << 8));
        e = (g ? 1 : 3) ** (c == 3 ? 4 : c);
        e = (50 * e + (2 ** (c == 3 ? 4 : c)) - 1) / (2 ** (c == 3 ? 4 : c));
        meas((e - 1) * TC, e * TC + 3);
        if (g == 0 && c == 0) begin
          cyc(1);
          chk(32'(o_irq), 32'h0000_0001);
          rchk(`OCR_ADDR_IRQ_STAT, 32'h0000_0003);
          wr(`OCR_ADDR_IRQ_STAT, 32'h0000_0003);
          cyc(2);
          chk(32'(o_irq), 32'h0000_0000);
        end
        m_mag <= '0;
        cyc(2 * TC + 2);
        chk(32'(o_trip), 32'h0000_0000);
      end
    end
    $display("test curves done");

    wr(`OCR_ADDR_RDELAY, 32'h0000_000A);
    for (int k = 0; k < 5; k++) begin
      m_mag <= '0;
      wr(`OCR_ADDR_CTRL, 32'h0000_0000);
      wr(`OCR_ADDR_CTRL, EN | 32'(rm[k] << 10));
      m_mag <= 16'h0200;
      cyc(30 * TC);
      m_mag <= '0;
      cyc(gp[k] * TC);
      meas((rr[k] - 2) * TC, (rr[k] + 1) * TC + 3);
    end
    $display("test reset modes done");

    m_mag <= '0;
    for (int k = 0; k < 7; k++) begin
      wr(`OCR_ADDR_PICKUP, {16'h0000, pk[k]});
      m_vmag <= vv[k];
      wr(`OCR_ADDR_CTRL, EN | INS | VR | 32'(wm[k] << 6));
      cyc(3);
      rchk(`OCR_ADDR_EFF_PICKUP, {16'h0000, ex[k]});
    end
    wr(`OCR_ADDR_PICKUP, 32'h0000_0100);
    m_vmag <= 16'h0080;
    m_mag <= 16'h0090;
    wr(`OCR_ADDR_CTRL, EN | INS | VR);
    cyc(4);
    chk(32'(o_pickup), 32'h0000_0001);
    wr(`OCR_ADDR_CTRL, EN | INS);
    cyc(4);
    chk(32'(o_pickup), 32'h0000_0000);
    $display("test restraint done");

    wr(`OCR_ADDR_IRQ_MASK, 32'h0000_0004);
    m_vmag <= 16'h0100;
    m_mag <= 16'h0200;
    i_vts_mcb_trip <= 1'b1;
    wr(`OCR_ADDR_CTRL, EN | INS | VR | VTS);
    cyc(4);
    chk(32'(o_pickup), 32'h0000_0000);
    rchk(`OCR_ADDR_STATUS, 32'h0000_0004);
    chk(32'(o_irq), 32'h0000_0001);
    wr(`OCR_ADDR_IRQ_STAT, 32'h0000_0004);
    cyc(2);
    chk(32'(o_irq), 32'h0000_0000);
    m_mode <= 2'd1;
    wr(`OCR_ADDR_CTRL, EN | INS | VR | VTS | NEG);
    cyc(4);
    chk(32'(o_pickup), 32'h0000_0000);
    m_mode <= 2'd2;
    cyc(4);
    chk(32'(o_pickup), 32'h0000_0001);
    i_vts_mcb_trip <= 1'b0;
    m_mag <= '0;
    wr(`OCR_ADDR_CTRL, 32'h0000_0000);
    wr(`OCR_ADDR_CTRL, EN | INS | NEG);
    meas(49 * TC, 50 * TC + 3);
    $display("test block and sequence done");
    report_and_stop();
  end
endmodule // tb_ocr_overcurrent
